// file: verilog/mxs_consts.svh
`ifndef MXS_CONSTS_SVH
`define MXS_CONSTS_SVH

// ------------------------------------------------------------
// widths
// ------------------------------------------------------------
`define MXS_PC_W        10
`define MXS_DATA_W      8
`define MXS_REG_ADDR_W  6
`define MXS_FIDX_W      4

// ------------------------------------------------------------
// vectors, reset values and pc steps
// ------------------------------------------------------------
`define MXS_TRAP_VEC    10'h001
`define MXS_PC_RST      10'h000
`define MXS_ACC_RST     8'h00
`define MXS_PC_STEP     10'h001
`define MXS_PC_SKIP     10'h002

// ------------------------------------------------------------
// cycle counts per opcode
// ------------------------------------------------------------
`define MXS_CYC_ONE     2'h1
`define MXS_CYC_SKIP    2'h2
`define MXS_CYC_TRAP    2'h3
`define MXS_CYC_FAR     2'h2

`endif

// file: verilog/mxs_pkg.sv
package mxs_pkg;

    typedef enum logic [3:0]
    {
        mxs_nop_op,
        mxs_inc_skip_zero_op,
        mxs_trap_op,
        mxs_or_acc_reg_op,
        mxs_or_acc_imm_op,
        mxs_fpage_read_op,
        mxs_fpage_write_op,
        mxs_far_call_op,
        mxs_far_jump_op
    } mxs_op_t;

    typedef enum logic
    {
        mxs_alu_inc,
        mxs_alu_or
    } mxs_alu_t;

    typedef enum logic
    {
        mxs_idle,
        mxs_wait
    } mxs_state_t;

endpackage

// file: verilog/mxs_alu_if.sv
`timescale 1ns/100ps
`include "mxs_consts.svh"

interface mxs_alu_if;
    import mxs_pkg::*;

    mxs_alu_t                   sel;
    logic [`MXS_DATA_W-1:0]     a;
    logic [`MXS_DATA_W-1:0]     b;
    logic [`MXS_DATA_W-1:0]     result;
    logic                       zero;

    modport alu  (input sel, input a, input b, output result, output zero);
    modport core (output sel, output a, output b, input result, input zero);
endinterface

// file: verilog/mxs_alu.sv
`timescale 1ns/100ps
`include "mxs_consts.svh"

module mxs_alu
    import mxs_pkg::*;
(
    mxs_alu_if.alu  bus
);
    always_comb
    begin
        unique case (bus.sel)
            mxs_alu_inc: bus.result = bus.a + `MXS_DATA_W'(1);
            mxs_alu_or:  bus.result = bus.a | bus.b;
        endcase
        bus.zero = (bus.result == '0);
    end
endmodule

// file: verilog/mxs_core.sv
`timescale 1ns/100ps
`include "mxs_consts.svh"

module mxs_core
    import mxs_pkg::*;
#(
    parameter int STACK_DEPTH = 8,
    parameter int SP_W        = $clog2(STACK_DEPTH)
)
(
    input  wire logic                           clk,
    input  wire logic                           sys_rst,
    input  wire logic                           op_valid,
    input  wire mxs_op_t                        op_kind,
    input  wire logic                           op_dest,
    input  wire logic [`MXS_REG_ADDR_W-1:0]     op_reg_addr,
    input  wire logic [`MXS_DATA_W-1:0]         op_imm,
    input  wire logic [`MXS_FIDX_W-1:0]         op_fidx,
    input  wire logic [`MXS_PC_W-1:0]           op_addr,
    input  wire logic [`MXS_DATA_W-1:0]         freg_rdata,
    input  wire logic [`MXS_DATA_W-1:0]         fpage_rdata,
    output logic                                busy,
    output logic                                discard_fetch,
    output logic [`MXS_PC_W-1:0]                pc,
    output logic [`MXS_DATA_W-1:0]              accumulator,
    output logic                                zflag,
    output logic                                freg_we,
    output logic [`MXS_REG_ADDR_W-1:0]          freg_waddr,
    output logic [`MXS_DATA_W-1:0]              freg_wdata,
    output logic                                fpage_we,
    output logic [`MXS_FIDX_W-1:0]              fpage_widx,
    output logic [`MXS_DATA_W-1:0]              fpage_wdata,
    output logic                                push_valid,
    output logic [`MXS_PC_W-1:0]                push_addr,
    output logic [SP_W-1:0]                     stack_ptr
);

    // ------------------------------------------------------------
    // shared arithmetic
    // ------------------------------------------------------------
    mxs_alu_if  alu_bus ();

    mxs_alu u_alu
    (
        .bus (alu_bus.alu)
    );

    function automatic logic [`MXS_PC_W-1:0] pc_add
    (
        input logic [`MXS_PC_W-1:0] base,
        input logic [`MXS_PC_W-1:0] step
    );
        pc_add = base + step;
    endfunction

    logic                       accept;
    logic [`MXS_PC_W-1:0]       pc_plus1;

    assign accept   = op_valid && !busy;
    assign pc_plus1 = pc_add(pc, `MXS_PC_STEP);

    always_comb
    begin
        alu_bus.sel = mxs_alu_or;
        alu_bus.a   = accumulator;
        alu_bus.b   = freg_rdata;
        unique case (op_kind)
            mxs_inc_skip_zero_op:
            begin
                alu_bus.sel = mxs_alu_inc;
                alu_bus.a   = freg_rdata;
            end
            mxs_or_acc_imm_op:
                alu_bus.b   = op_imm;
            default:
                alu_bus.b   = freg_rdata;
        endcase
    end

    // ------------------------------------------------------------
    // sequencing and datapath
    // ------------------------------------------------------------
    mxs_state_t                 state;
    mxs_state_t                 next_state;
    logic [1:0]                 wait_cnt;
    logic [1:0]                 next_wait_cnt;
    logic                       next_busy;
    logic                       next_discard_fetch;
    logic [`MXS_PC_W-1:0]       next_pc;
    logic [`MXS_DATA_W-1:0]     next_accumulator;
    logic                       next_zflag;
    logic                       next_freg_we;
    logic [`MXS_REG_ADDR_W-1:0] next_freg_waddr;
    logic [`MXS_DATA_W-1:0]     next_freg_wdata;
    logic                       next_fpage_we;
    logic [`MXS_FIDX_W-1:0]     next_fpage_widx;
    logic [`MXS_DATA_W-1:0]     next_fpage_wdata;
    logic                       next_push_valid;
    logic [`MXS_PC_W-1:0]       next_push_addr;
    logic [SP_W-1:0]            next_stack_ptr;
    logic [1:0]                 cycles;

    always_comb
    begin
        cycles             = `MXS_CYC_ONE;
        next_state         = state;
        next_wait_cnt      = wait_cnt;
        next_discard_fetch = 1'b0;
        next_pc            = pc;
        next_accumulator   = accumulator;
        next_zflag         = zflag;
        next_freg_we       = 1'b0;
        next_freg_waddr    = freg_waddr;
        next_freg_wdata    = freg_wdata;
        next_fpage_we      = 1'b0;
        next_fpage_widx    = fpage_widx;
        next_fpage_wdata   = fpage_wdata;
        next_push_valid    = 1'b0;
        next_push_addr     = push_addr;
        next_stack_ptr     = stack_ptr;
        unique case (state)
            mxs_idle:
            if (accept)
            begin
                next_pc = pc_plus1;
                unique case (op_kind)
                    mxs_inc_skip_zero_op:
                    begin
                        if (op_dest)
                        begin
                            next_freg_we    = 1'b1;
                            next_freg_waddr = op_reg_addr;
                            next_freg_wdata = alu_bus.result;
                        end
                        else
                            next_accumulator = alu_bus.result;
                        // skipped slot runs as a nop: pc steps past it
                        if (alu_bus.zero)
                        begin
                            cycles             = `MXS_CYC_SKIP;
                            next_discard_fetch = 1'b1;
                            next_pc = pc_add(pc, `MXS_PC_SKIP);
                        end
                    end
                    mxs_trap_op:
                    begin
                        cycles          = `MXS_CYC_TRAP;
                        next_push_valid = 1'b1;
                        next_push_addr  = pc_plus1;
                        next_stack_ptr  = stack_ptr + SP_W'(1);
                        next_pc         = `MXS_TRAP_VEC;
                    end
                    mxs_or_acc_reg_op, mxs_or_acc_imm_op:
                    begin
                        next_zflag = alu_bus.zero;
                        if (op_dest && op_kind == mxs_or_acc_reg_op)
                        begin
                            next_freg_we    = 1'b1;
                            next_freg_waddr = op_reg_addr;
                            next_freg_wdata = alu_bus.result;
                        end
                        else
                            next_accumulator = alu_bus.result;
                    end
                    mxs_fpage_read_op:
                        next_accumulator = fpage_rdata;
                    mxs_fpage_write_op:
                    begin
                        next_fpage_we    = 1'b1;
                        next_fpage_widx  = op_fidx;
                        next_fpage_wdata = accumulator;
                    end
                    mxs_far_call_op:
                    begin
                        cycles          = `MXS_CYC_FAR;
                        next_push_valid = 1'b1;
                        next_push_addr  = pc_plus1;
                        next_stack_ptr  = stack_ptr + SP_W'(1);
                        next_pc         = op_addr;
                    end
                    mxs_far_jump_op:
                    begin
                        cycles  = `MXS_CYC_FAR;
                        next_pc = op_addr;
                    end
                    default:
                        next_pc = pc_plus1;
                endcase
                next_wait_cnt = cycles - 2'h1;
                if (next_wait_cnt != 2'h0)
                    next_state = mxs_wait;
            end
            mxs_wait:
            begin
                next_wait_cnt = wait_cnt - 2'h1;
                if (next_wait_cnt == 2'h0)
                    next_state = mxs_idle;
            end
        endcase
        next_busy = (next_state == mxs_wait);
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state         <= mxs_idle;
            wait_cnt      <= 2'h0;
            busy          <= 1'b0;
            discard_fetch <= 1'b0;
            pc            <= `MXS_PC_RST;
            accumulator   <= `MXS_ACC_RST;
            zflag         <= 1'b0;
            freg_we       <= 1'b0;
            freg_waddr    <= '0;
            freg_wdata    <= '0;
            fpage_we      <= 1'b0;
            fpage_widx    <= '0;
            fpage_wdata   <= '0;
            push_valid    <= 1'b0;
            push_addr     <= `MXS_PC_RST;
            stack_ptr     <= '0;
        end
        else
        begin
            state         <= next_state;
            wait_cnt      <= next_wait_cnt;
            busy          <= next_busy;
            discard_fetch <= next_discard_fetch;
            pc            <= next_pc;
            accumulator   <= next_accumulator;
            zflag         <= next_zflag;
            freg_we       <= next_freg_we;
            freg_waddr    <= next_freg_waddr;
            freg_wdata    <= next_freg_wdata;
            fpage_we      <= next_fpage_we;
            fpage_widx    <= next_fpage_widx;
            fpage_wdata   <= next_fpage_wdata;
            push_valid    <= next_push_valid;
            push_addr     <= next_push_addr;
            stack_ptr     <= next_stack_ptr;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic acc_inc;
    assign acc_inc = accept && op_kind == mxs_inc_skip_zero_op;

    // the destination bit may already belong to the next opcode
    property p_inc_dest;
        acc_inc |=> ($past(op_dest)
            ? (freg_we && freg_wdata == $past(alu_bus.result))
            : (!freg_we && accumulator == $past(alu_bus.result)));
    endproperty
    a_inc_dest: assert property (p_inc_dest) else $error("inc dest");

    property p_inc_skip;
        acc_inc && alu_bus.zero |=> discard_fetch && busy ##1 !busy;
    endproperty
    a_inc_skip: assert property (p_inc_skip) else $error("skip");

    property p_inc_noskip;
        acc_inc && !alu_bus.zero |=> !discard_fetch && !busy;
    endproperty
    a_inc_noskip: assert property (p_inc_noskip) else $error("noskip");

    property p_trap;
        accept && op_kind == mxs_trap_op |=> push_valid
            && push_addr == $past(pc_plus1) && pc == `MXS_TRAP_VEC
            && busy ##1 busy ##1 !busy;
    endproperty
    a_trap: assert property (p_trap) else $error("trap");

    property p_or_reg;
        accept && op_kind == mxs_or_acc_reg_op |=>
            zflag == $past(alu_bus.zero) && !busy
            && (freg_we == $past(op_dest));
    endproperty
    a_or_reg: assert property (p_or_reg) else $error("or reg");

    property p_or_imm;
        accept && op_kind == mxs_or_acc_imm_op |=>
            accumulator == ($past(accumulator) | $past(op_imm))
            && zflag == (accumulator == 8'h00) && !freg_we;
    endproperty
    a_or_imm: assert property (p_or_imm) else $error("or imm");

    property p_fread;
        accept && op_kind == mxs_fpage_read_op |=>
            accumulator == $past(fpage_rdata) && zflag == $past(zflag);
    endproperty
    a_fread: assert property (p_fread) else $error("fpage read");

    property p_fwrite;
        accept && op_kind == mxs_fpage_write_op |=> fpage_we
            && fpage_wdata == $past(accumulator)
            && accumulator == $past(accumulator);
    endproperty
    a_fwrite: assert property (p_fwrite) else $error("fpage write");

    property p_call;
        accept && op_kind == mxs_far_call_op |=> push_valid
            && stack_ptr == $past(stack_ptr) + SP_W'(1)
            && pc == $past(op_addr) && busy ##1 !busy;
    endproperty
    a_call: assert property (p_call) else $error("far call");

    property p_jump;
        accept && op_kind == mxs_far_jump_op |=> !push_valid
            && stack_ptr == $past(stack_ptr) && pc == $past(op_addr)
            && busy ##1 !busy;
    endproperty
    a_jump: assert property (p_jump) else $error("far jump");

    property p_seq;
        accept && (op_kind == mxs_or_acc_imm_op
            || op_kind == mxs_fpage_write_op) |=> pc == $past(pc_plus1);
    endproperty
    a_seq: assert property (p_seq) else $error("pc step");

    c_skip: cover property (acc_inc && alu_bus.zero);
    c_trap: cover property (accept && op_kind == mxs_trap_op);
    c_call: cover property (accept && op_kind == mxs_far_call_op);
    c_back: cover property (accept ##1 accept);
endmodule

// file: sim/tb.sv
`timescale 1ns/100ps
`include "mxs_consts.svh"

module tb
    import mxs_pkg::*;
;
    localparam int SP_W = 3;

    logic                          clk = 1'b0;
    logic                          sys_rst = 1'b1;
    logic                          op_valid = 1'b0;
    mxs_op_t                       op_kind = mxs_nop_op;
    logic                          op_dest = 1'b0;
    logic [`MXS_REG_ADDR_W-1:0]    op_reg_addr = 6'h00;
    logic [`MXS_DATA_W-1:0]        op_imm = 8'h00;
    logic [`MXS_FIDX_W-1:0]        op_fidx = 4'h0;
    logic [`MXS_PC_W-1:0]          op_addr = 10'h000;
    logic [`MXS_DATA_W-1:0]        freg_rdata = 8'h00;
    logic [`MXS_DATA_W-1:0]        fpage_rdata = 8'h00;
    logic                          busy;
    logic                          discard_fetch;
    logic [`MXS_PC_W-1:0]          pc;
    logic [`MXS_DATA_W-1:0]        accumulator;
    logic                          zflag;
    logic                          freg_we;
    logic [`MXS_REG_ADDR_W-1:0]    freg_waddr;
    logic [`MXS_DATA_W-1:0]        freg_wdata;
    logic                          fpage_we;
    logic [`MXS_FIDX_W-1:0]        fpage_widx;
    logic [`MXS_DATA_W-1:0]        fpage_wdata;
    logic                          push_valid;
    logic [`MXS_PC_W-1:0]          push_addr;
    logic [SP_W-1:0]               stack_ptr;

    int                            n_fail = 0;
    int                            compares = 0;
    int                            cyc;
    logic                          s_we;
    logic                          s_fwe;
    logic                          s_push;
    logic                          s_disc;
    logic [`MXS_PC_W-1:0]          ep;
    logic [SP_W-1:0]               esp;
    logic [`MXS_DATA_W-1:0]        acc0;

    always #4 clk = ~clk;

    mxs_core #(.STACK_DEPTH(8)) u_dut
    (
        .clk           (clk),
        .sys_rst       (sys_rst),
        .op_valid      (op_valid),
        .op_kind       (op_kind),
        .op_dest       (op_dest),
        .op_reg_addr   (op_reg_addr),
        .op_imm        (op_imm),
        .op_fidx       (op_fidx),
        .op_addr       (op_addr),
        .freg_rdata    (freg_rdata),
        .fpage_rdata   (fpage_rdata),
        .busy          (busy),
        .discard_fetch (discard_fetch),
        .pc            (pc),
        .accumulator   (accumulator),
        .zflag         (zflag),
        .freg_we       (freg_we),
        .freg_waddr    (freg_waddr),
        .freg_wdata    (freg_wdata),
        .fpage_we      (fpage_we),
        .fpage_widx    (fpage_widx),
        .fpage_wdata   (fpage_wdata),
        .push_valid    (push_valid),
        .push_addr     (push_addr),
        .stack_ptr     (stack_ptr)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string msg);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: %s seen %h want %h", $time, msg,
                     seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // pulses stand one cycle, so they are latched on the first cycle;
    // one idle cycle first, so op_valid never toggles twice in a step
    task automatic run_op(input mxs_op_t k, input logic d,
                          input logic [7:0] rd);
        @(negedge clk);
        op_kind = k;
        op_dest = d;
        freg_rdata = rd;
        fpage_rdata = rd;
        op_valid = 1'b1;
        @(negedge clk);
        op_valid = 1'b0;
        s_we = freg_we;
        s_fwe = fpage_we;
        s_push = push_valid;
        s_disc = discard_fetch;
        cyc = 1;
        while (busy === 1'b1 && cyc < 8)
        begin
            @(negedge clk);
            cyc++;
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_or_imm(input logic [7:0] i);
        acc0 = accumulator;
        op_imm = i;
        run_op(mxs_or_acc_imm_op, 1'b0, 8'h00);
        ep = ep + 10'h001;
        check(16'(accumulator), 16'(acc0 | i), "or imm acc");
        check(16'(zflag), 16'((acc0 | i) == 8'h00), "or imm z");
        check(16'(cyc), 16'd1, "or imm cycles");
        check(16'(pc), 16'(ep), "or imm pc");
    endtask

    task automatic t_or_reg(input logic d, input logic [7:0] r);
        acc0 = accumulator;
        op_reg_addr = 6'h3f;
        run_op(mxs_or_acc_reg_op, d, r);
        ep = ep + 10'h001;
        check(16'(s_we), 16'(d), "or reg we");
        if (d)
        begin
            check(16'(freg_waddr), 16'h003f, "or reg addr");
            check(16'(freg_wdata), 16'(acc0 | r), "or reg data");
        end
        check(16'(accumulator), 16'(d ? acc0 : acc0 | r),
              "or reg acc");
        check(16'(zflag), 16'((acc0 | r) == 8'h00), "or reg z");
        check(16'(cyc), 16'd1, "or reg cycles");
        check(16'(pc), 16'(ep), "or reg pc");
    endtask

    task automatic t_inc(input logic d, input logic [7:0] r);
        logic z0;
        logic [7:0] sum;
        acc0 = accumulator;
        z0 = zflag;
        sum = r + 8'h01;
        op_reg_addr = 6'h15;
        run_op(mxs_inc_skip_zero_op, d, r);
        ep = ep + ((sum == 8'h00) ? 10'h002 : 10'h001);
        check(16'(s_we), 16'(d), "inc we");
        if (d)
        begin
            check(16'(freg_waddr), 16'h0015, "inc addr");
            check(16'(freg_wdata), 16'(sum), "inc data");
        end
        check(16'(accumulator), 16'(d ? acc0 : sum), "inc acc");
        check(16'(s_disc), 16'(sum == 8'h00), "inc discard");
        check(16'(cyc), (sum == 8'h00) ? 16'd2 : 16'd1, "inc cycles");
        check(16'(pc), 16'(ep), "inc pc");
        check(16'(zflag), 16'(z0), "inc z kept");
    endtask

    task automatic t_fpage(input logic [7:0] v);
        logic z0;
        z0 = zflag;
        op_fidx = 4'hf;
        run_op(mxs_fpage_read_op, 1'b0, v);
        ep = ep + 10'h001;
        check(16'(accumulator), 16'(v), "fpage read acc");
        check(16'(zflag), 16'(z0), "fpage read z");
        check(16'(cyc), 16'd1, "fpage read cycles");
        op_fidx = 4'h9;
        run_op(mxs_fpage_write_op, 1'b0, 8'h00);
        ep = ep + 10'h001;
        check(16'(s_fwe), 16'h0001, "fpage we");
        check(16'(fpage_widx), 16'h0009, "fpage idx");
        check(16'(fpage_wdata), 16'(v), "fpage data");
        check(16'(accumulator), 16'(v), "fpage acc kept");
        check(16'(cyc), 16'd1, "fpage write cycles");
        check(16'(pc), 16'(ep), "fpage pc");
    endtask

    task automatic t_branch(input mxs_op_t k, input logic [9:0] a,
                            input logic pushes, input int n);
        op_addr = a;
        run_op(k, 1'b0, 8'h00);
        check(16'(s_push), 16'(pushes), "push pulse");
        if (pushes)
        begin
            check(16'(push_addr), 16'(ep + 10'h001), "push addr");
            esp = esp + 3'h1;
        end
        check(16'(stack_ptr), 16'(esp), "stack ptr");
        ep = (k == mxs_trap_op) ? `MXS_TRAP_VEC : a;
        check(16'(pc), 16'(ep), "branch pc");
        check(16'(cyc), 16'(n), "branch cycles");
    endtask

    // an opcode offered while busy is ignored; then two back to back
    task automatic t_refuse();
        acc0 = accumulator;
        @(negedge clk);
        op_kind = mxs_trap_op;
        op_valid = 1'b1;
        @(negedge clk);
        op_kind = mxs_or_acc_imm_op;
        op_imm = 8'hff;
        @(negedge clk);
        op_valid = 1'b0;
        @(negedge clk);
        check(16'(busy), 16'h0000, "trap done");
        check(16'(accumulator), 16'(acc0), "busy refuse acc");
        check(16'(pc), 16'(`MXS_TRAP_VEC), "busy refuse pc");
        op_imm = 8'h01;
        op_valid = 1'b1;
        @(negedge clk);
        op_imm = 8'h02;
        @(negedge clk);
        op_valid = 1'b0;
        check(16'(accumulator), 16'(acc0 | 8'h03), "b2b acc");
        check(16'(pc), 16'(`MXS_TRAP_VEC + 10'h002), "b2b pc");
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (5) @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
        check(16'(pc), 16'h0000, "reset pc");
        check(16'(accumulator), 16'h0000, "reset acc");
        check(16'(busy), 16'h0000, "reset busy");
        ep = 10'h000;
        esp = 3'h0;
        t_or_imm(8'h00);
        t_or_imm(8'h50);
        t_or_reg(1'b0, 8'h0a);
        t_or_reg(1'b1, 8'h05);
        t_inc(1'b0, 8'h7f);
        t_inc(1'b1, 8'hff);
        t_inc(1'b0, 8'hff);
        t_fpage(8'h00);
        t_fpage(8'h3c);
        t_branch(mxs_trap_op, 10'h000, 1'b1, 3);
        t_branch(mxs_far_call_op, 10'h3ff, 1'b1, 2);
        t_branch(mxs_far_jump_op, 10'h2a5, 1'b0, 2);
        t_refuse();
        report_and_stop();
    end

    // the sequence needs well under 200 cycles
    initial
    begin
        #(2000 * 8);
        n_fail++;
        $display("mismatch at %0t: watchdog expired", $time);
        report_and_stop();
    end
endmodule
